// file: core/vmd_pkg.sv
// Shared constants and types for the vector and register map decoder
package vmd_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_VEC = 32;
	localparam int VEC_IDX_W = 5;
	// Direct page, high page, nonvolatile area bounds
	localparam logic [15:0] DP_LO = 16'h0000;
	localparam logic [15:0] DP_HI = 16'h007F;
	localparam logic [15:0] HP_LO = 16'h1800;
	localparam logic [15:0] HP_HI = 16'h18FF;
	localparam logic [15:0] NV_LO = 16'hFFB0;
	localparam logic [15:0] NV_HI = 16'hFFBF;
	// Vector table
	localparam logic [15:0] VEC_BASE = 16'hFFC0;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_SWI = 16'hFFFC;
	localparam logic [15:0] VEC_IRQ = 16'hFFFA;
	localparam logic [15:0] VEC_LVD = 16'hFFF8;
	localparam logic [15:0] VEC_LOL = 16'hFFF6;
	localparam logic [15:0] VEC_PORT = 16'hFFD2;
	// Slot indexes counted from VEC_BASE
	localparam logic [4:0] SLOT_RESET = 5'h1F;
	localparam logic [4:0] SLOT_SWI = 5'h1E;
	localparam logic [4:0] SLOT_IRQ = 5'h1D;
	localparam logic [4:0] SLOT_LVD = 5'h1C;
	localparam logic [4:0] SLOT_LOL = 5'h1B;
	localparam logic [4:0] SLOT_PORT = 5'h09;
	// Nonvolatile area offsets (within the 16-byte area)
	localparam logic [3:0] NV_KEY_FIRST = 4'h0;
	localparam logic [3:0] NV_KEY_LAST = 4'h7;
	localparam logic [3:0] NV_PROT_OFS = 4'hD;
	localparam logic [3:0] NV_OPT_OFS = 4'hF;
	localparam int NV_KEY_BYTES = 8;
	localparam int NV_BYTES = 16;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] HIGH_BYTE_ZERO = 8'h00;
	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	localparam logic [7:0] MASK_ALL = 8'hFF;

	// Region select
	typedef enum logic [2:0] {
		VMD_RGN_NONE = 3'b000,
		VMD_RGN_DP = 3'b001,
		VMD_RGN_HP = 3'b010,
		VMD_RGN_NV = 3'b011,
		VMD_RGN_VEC = 3'b100
	} vmd_region_type;

	// Core access request
	typedef struct packed {
		logic valid;
		logic write;
		logic direct;
		logic [15:0] addr;
		logic [7:0] wdata;
	} vmd_req_type;

	// Decoded select passed to the peripheral side
	typedef struct packed {
		vmd_region_type region;
		logic [7:0] offset;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} vmd_sel_type;
endpackage

// file: core/vmd_vec_slot.sv
// Vector slot calculator: source number to slot address pair
`timescale 1ns/1ns
module vmd_vec_slot (
	input wire logic [4:0] slot_idx,
	output logic [15:0] slot_hi_addr,
	output logic [15:0] slot_lo_addr
);
	// Each slot is two bytes, high byte first
	always_comb begin
		slot_hi_addr = vmd_pkg::VEC_BASE + {10'h000, slot_idx, 1'b0};
		slot_lo_addr = slot_hi_addr + 16'h0001;
	end
endmodule // vmd_vec_slot

// file: core/vmd_decode.sv
// Memory map decoder: vectors, register pages, nonvolatile area
`timescale 1ns/1ns
module vmd_decode #(
	parameter int NUM_SRC = vmd_pkg::NUM_VEC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire vmd_pkg::vmd_req_type core_req,
	input wire logic [4:0] irq_src,
	input wire logic vec_fetch,
	input wire logic [7:0] periph_rdata,
	input wire logic [7:0] periph_zero_mask,
	input wire logic [7:0] periph_impl_mask,
	input wire logic [7:0] flash_rdata,
	input wire logic [7:0] bitop_mask,
	input wire logic bitop_set,
	input wire logic bitop_clr,
	output vmd_pkg::vmd_sel_type periph_sel,
	output logic [15:0] flash_addr,
	output logic [7:0] rdata,
	output logic bit_test,
	output logic [15:0] vec_addr,
	output logic [7:0] nv_protection_byte,
	output logic [7:0] nv_option_byte,
	output logic [63:0] backdoor_key,
	output logic key_ready,
	output logic ready
);
	// Load sequencer after reset: protection, option, then key bytes
	typedef enum logic [1:0] {
		VMD_LD_PROT = 2'b00,
		VMD_LD_OPT = 2'b01,
		VMD_LD_KEY = 2'b10,
		VMD_LD_DONE = 2'b11
	} vmd_load_type;

	vmd_load_type ld_reg, ld_next;
	logic [2:0] key_idx_reg, key_idx_next;
	logic [7:0] prot_reg, prot_next;
	logic [7:0] opt_reg, opt_next;
	logic [63:0] key_reg, key_next;
	logic [7:0] rdata_reg, rdata_next;
	logic bit_test_reg, bit_test_next;
	logic [15:0] eff_addr;
	vmd_pkg::vmd_region_type region;
	logic [15:0] slot_hi, slot_lo;
	logic [4:0] slot_idx;
	logic [15:0] load_addr;
	logic [7:0] write_bits;

	// Direct mode forces the high byte to zero
	assign eff_addr = core_req.direct ?
		{vmd_pkg::HIGH_BYTE_ZERO, core_req.addr[7:0]} : core_req.addr;

	// Region decode; unlisted addresses stay with memory
	always_comb begin
		if (eff_addr <= vmd_pkg::DP_HI) begin
			region = vmd_pkg::VMD_RGN_DP;
		end else if (eff_addr >= vmd_pkg::HP_LO && eff_addr <= vmd_pkg::HP_HI) begin
			region = vmd_pkg::VMD_RGN_HP;
		end else if (eff_addr >= vmd_pkg::NV_LO && eff_addr <= vmd_pkg::NV_HI) begin
			region = vmd_pkg::VMD_RGN_NV;
		end else if (eff_addr >= vmd_pkg::VEC_BASE) begin
			region = vmd_pkg::VMD_RGN_VEC;
		end else begin
			region = vmd_pkg::VMD_RGN_NONE;
		end
	end

	// Slot taken straight from irq_src once loaded; reset slot while loading
	always_comb begin
		if (ld_reg != VMD_LD_DONE) begin
			slot_idx = vmd_pkg::SLOT_RESET;
		end else begin
			slot_idx = irq_src;
		end
	end

	vmd_vec_slot u_slot (
		.slot_idx(slot_idx),
		.slot_hi_addr(slot_hi),
		.slot_lo_addr(slot_lo)
	);

	assign vec_addr = vec_fetch ? slot_lo : slot_hi;

	// Read-modify-write for bit ops: only implemented bits change
	always_comb begin
		write_bits = core_req.wdata;
		if (bitop_set) begin
			write_bits = periph_rdata | bitop_mask;
		end else if (bitop_clr) begin
			write_bits = periph_rdata & ~bitop_mask;
		end
		write_bits = write_bits & periph_impl_mask;
	end

	// Peripheral select; nonvolatile writes never reach storage
	always_comb begin
		periph_sel.region = region;
		periph_sel.offset = eff_addr[7:0];
		periph_sel.wdata = write_bits;
		periph_sel.rd = core_req.valid && !core_req.write &&
			(region == vmd_pkg::VMD_RGN_DP || region == vmd_pkg::VMD_RGN_HP);
		periph_sel.wr = core_req.valid && core_req.write &&
			(periph_impl_mask != vmd_pkg::BYTE_ZERO) &&
			(region == vmd_pkg::VMD_RGN_DP || region == vmd_pkg::VMD_RGN_HP);
	end

	// Flash address: loader owns the port until done
	always_comb begin
		unique case (ld_reg)
			VMD_LD_PROT: load_addr = {vmd_pkg::NV_LO[15:4], vmd_pkg::NV_PROT_OFS};
			VMD_LD_OPT: load_addr = {vmd_pkg::NV_LO[15:4], vmd_pkg::NV_OPT_OFS};
			VMD_LD_KEY: load_addr = {vmd_pkg::NV_LO[15:4], 1'b0, key_idx_reg};
			VMD_LD_DONE: load_addr = eff_addr;
		endcase
	end
	assign flash_addr = load_addr;

	// Loader next state: flash data assumed valid same cycle
	always_comb begin
		ld_next = ld_reg;
		key_idx_next = key_idx_reg;
		prot_next = prot_reg;
		opt_next = opt_reg;
		key_next = key_reg;
		unique case (ld_reg)
			VMD_LD_PROT: begin
				prot_next = flash_rdata;
				ld_next = VMD_LD_OPT;
			end
			VMD_LD_OPT: begin
				opt_next = flash_rdata;
				ld_next = VMD_LD_KEY;
			end
			VMD_LD_KEY: begin
				key_next = {key_reg[55:0], flash_rdata};
				key_idx_next = key_idx_reg + 3'h1;
				if (key_idx_reg == vmd_pkg::NV_KEY_LAST[2:0]) begin
					ld_next = VMD_LD_DONE;
				end
			end
			VMD_LD_DONE: begin
			end
		endcase
	end

	// Read data: zero bits forced low; flash writes ignored
	always_comb begin
		rdata_next = rdata_reg;
		bit_test_next = bit_test_reg;
		if (core_req.valid && !core_req.write && ld_reg == VMD_LD_DONE) begin
			unique case (region)
				vmd_pkg::VMD_RGN_DP, vmd_pkg::VMD_RGN_HP: begin
					rdata_next = periph_rdata & ~periph_zero_mask;
					bit_test_next = |(periph_rdata & ~periph_zero_mask
						& bitop_mask);
				end
				vmd_pkg::VMD_RGN_NV, vmd_pkg::VMD_RGN_VEC: begin
					rdata_next = flash_rdata;
				end
				vmd_pkg::VMD_RGN_NONE: begin
					rdata_next = vmd_pkg::BYTE_ZERO;
				end
				default: begin
					rdata_next = vmd_pkg::BYTE_ZERO;
				end
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ld_reg <= VMD_LD_PROT;
			key_idx_reg <= 3'h0;
			prot_reg <= vmd_pkg::BYTE_ZERO;
			opt_reg <= vmd_pkg::BYTE_ZERO;
			key_reg <= 64'h0000000000000000;
			rdata_reg <= vmd_pkg::BYTE_ZERO;
			bit_test_reg <= 1'b0;
		end else begin
			ld_reg <= ld_next;
			key_idx_reg <= key_idx_next;
			prot_reg <= prot_next;
			opt_reg <= opt_next;
			key_reg <= key_next;
			rdata_reg <= rdata_next;
			bit_test_reg <= bit_test_next;
		end
	end

	assign nv_protection_byte = prot_reg;
	assign nv_option_byte = opt_reg;
	assign backdoor_key = key_reg;
	assign key_ready = (ld_reg == VMD_LD_DONE);
	assign ready = key_ready;
	assign rdata = rdata_reg;
	assign bit_test = bit_test_reg;

	// Checks
	reset_vec_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		!key_ready |-> vec_addr[15:1] == vmd_pkg::VEC_RESET[15:1])
		else $error("reset vector slot not selected while loading");
	port_slot_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		key_ready && irq_src == vmd_pkg::SLOT_PORT && !vec_fetch
		|-> vec_addr == vmd_pkg::VEC_PORT)
		else $error("port vector slot wrong");
	lol_slot_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		key_ready && irq_src == vmd_pkg::SLOT_LOL && vec_fetch
		|-> vec_addr == vmd_pkg::VEC_LOL + 16'h0001)
		else $error("clock lock loss slot wrong");
	// Upper half of a direct address is RAM, never a register
	direct_page_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		core_req.valid && core_req.direct
		|-> periph_sel.region == (core_req.addr[7] ?
			vmd_pkg::VMD_RGN_NONE : vmd_pkg::VMD_RGN_DP))
		else $error("direct address decoded to wrong region");
	high_page_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		core_req.valid && !core_req.direct && core_req.addr[15:8] == 8'h18
		|-> periph_sel.region == vmd_pkg::VMD_RGN_HP)
		else $error("high page miss");
	nv_nowrite_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		periph_sel.region == vmd_pkg::VMD_RGN_NV |-> !periph_sel.wr)
		else $error("write leaked into nonvolatile area");
	load_done_a: assert property (@(posedge clk_sys)
		$fell(srst) |-> ##10 key_ready)
		else $error("nonvolatile load did not finish in ten cycles");
	prot_copy_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		ld_reg == VMD_LD_PROT |=> nv_protection_byte == $past(flash_rdata))
		else $error("protection byte not copied");
	zero_bits_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		core_req.valid && !core_req.write && key_ready &&
		periph_sel.rd |=> (rdata & $past(periph_zero_mask)) == 8'h00)
		else $error("unused zero bit read as one");
	resv_write_a: assert property (@(posedge clk_sys)
		disable iff (srst)
		periph_impl_mask == 8'h00 |-> !periph_sel.wr)
		else $error("write to reserved location reached peripherals");

	cov_load: cover property (@(posedge clk_sys) $rose(key_ready));
	cov_dp_read: cover property (@(posedge clk_sys) periph_sel.rd &&
		periph_sel.region == vmd_pkg::VMD_RGN_DP);
	cov_hp_write: cover property (@(posedge clk_sys) periph_sel.wr &&
		periph_sel.region == vmd_pkg::VMD_RGN_HP);
	cov_bitset: cover property (@(posedge clk_sys) bitop_set && periph_sel.wr);
endmodule // vmd_decode

// file: test/vmd_flash_model.sv
// Flash array model answering the decoder's nonvolatile fetches
`timescale 1ns/1ns
module vmd_flash_model (
	input wire logic [15:0] flash_addr,
	output logic [7:0] flash_rdata
);
	// Byte i of the area reads {i, ~i} so each key byte is distinct
	always_comb begin
		if (flash_addr[15:4] == 12'hFFB) begin
			flash_rdata = {flash_addr[3:0], ~flash_addr[3:0]};
		end else begin
			// Outside the area, a changing pattern instead of stale data
			flash_rdata = flash_addr[7:0] ^ 8'hA5;
		end
	end
endmodule // vmd_flash_model

// file: test/vmd_decode_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ns
module vmd_decode_tb;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	vmd_pkg::vmd_req_type core_req = '0;
	logic [4:0] irq_src = 5'h00;
	logic vec_fetch = 1'b0;
	logic [7:0] periph_rdata = 8'h00;
	logic [7:0] periph_zero_mask = 8'h00;
	logic [7:0] periph_impl_mask = 8'hFF;
	logic [7:0] bitop_mask = 8'h00;
	logic bitop_set = 1'b0;
	logic bitop_clr = 1'b0;
	logic [7:0] flash_rdata;
	vmd_pkg::vmd_sel_type periph_sel;
	logic [15:0] flash_addr;
	logic [15:0] vec_addr;
	logic [7:0] rdata;
	logic [7:0] nv_protection_byte;
	logic [7:0] nv_option_byte;
	logic [63:0] backdoor_key;
	logic bit_test;
	logic key_ready;
	logic ready;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	vmd_decode u_dut (.clk_sys(clk_sys), .srst(srst), .core_req(core_req),
		.irq_src(irq_src), .vec_fetch(vec_fetch),
		.periph_rdata(periph_rdata), .periph_zero_mask(periph_zero_mask),
		.periph_impl_mask(periph_impl_mask), .flash_rdata(flash_rdata),
		.bitop_mask(bitop_mask), .bitop_set(bitop_set),
		.bitop_clr(bitop_clr), .periph_sel(periph_sel),
		.flash_addr(flash_addr), .rdata(rdata), .bit_test(bit_test),
		.vec_addr(vec_addr), .nv_protection_byte(nv_protection_byte),
		.nv_option_byte(nv_option_byte), .backdoor_key(backdoor_key),
		.key_ready(key_ready), .ready(ready));
	vmd_flash_model u_flash (.flash_addr(flash_addr),
		.flash_rdata(flash_rdata));

	// 125 MHz clock
	always #4 clk_sys = ~clk_sys;

	task automatic chk(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Inputs always move 1 ns after the rising edge
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic req(input logic wr, input logic dir, input logic [15:0] a);
		core_req = '{valid: 1'b1, write: wr, direct: dir, addr: a,
			wdata: 8'h5A};
		#1;
	endtask

	// Reset vector during reset, then the nonvolatile copy; also mid-run
	task automatic test_reset;
		int n;
		n = 0;
		srst = 1'b1;
		vec_fetch = 1'b0;
		irq_src = vmd_pkg::SLOT_PORT;
		periph_rdata = 8'hFF;
		periph_zero_mask = 8'h00;
		// A read held through loading must be refused
		core_req = '{valid: 1'b1, write: 1'b0, direct: 1'b0,
			addr: 16'h000C, wdata: 8'h00};
		tick();
		tick();
		chk("reset vec", vec_addr, 16'hFFFE);
		vec_fetch = 1'b1;
		srst = 1'b0;
		#1;
		chk("reset vec lo", vec_addr, 16'hFFFF);
		while (ready !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		chk("load cycles", n, 10);
		chk("ready", ready, 1'b1);
		chk("refused read", rdata, 8'h00);
		vec_fetch = 1'b0;
		core_req.valid = 1'b0;
		periph_rdata = 8'h00;
		chk("prot byte", nv_protection_byte, 8'hD2);
		chk("opt byte", nv_option_byte, 8'hF0);
		chk("key", backdoor_key, 64'h0F1E2D3C4B5A6978);
		chk("key ready", key_ready, 1'b1);
	endtask

	// Every slot, both halves; slot 9 is the shared port slot
	task automatic test_vectors;
		for (int i = 0; i < 32; i++) begin
			for (int f = 0; f < 2; f++) begin
				tick();
				irq_src = 5'(i);
				vec_fetch = f[0];
				#1;
				chk("vec addr", vec_addr, 16'hFFC0 + 16'(2 * i + f));
			end
		end
	endtask

	// Region boundaries, read strobe and offset
	task automatic test_decode;
		logic [15:0] a[10] = '{16'h0000, 16'h007F, 16'h0080, 16'h17FF,
			16'h1800, 16'h18FF, 16'h1900, 16'hFFB0, 16'hFFBF, 16'hFFAF};
		logic [2:0] r[10] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0,
			3'h3, 3'h3, 3'h0};
		for (int i = 0; i < 10; i++) begin
			tick();
			req(1'b0, 1'b0, a[i]);
			chk("region", periph_sel.region, r[i]);
			if (r[i] == 3'h1 || r[i] == 3'h2)
				chk("offset", periph_sel.offset, a[i][7:0]);
		end
		// Direct mode ignores the upper byte
		tick();
		req(1'b0, 1'b1, 16'h3410);
		chk("direct region", periph_sel.region, 3'h1);
		chk("direct offset", periph_sel.offset, 8'h10);
		chk("direct rd", periph_sel.rd, 1'b1);
	endtask

	// Port G style register: top two bits must read zero
	task automatic test_read;
		tick();
		periph_rdata = 8'hFF;
		periph_zero_mask = 8'hC0;
		bitop_mask = 8'h20;
		req(1'b0, 1'b0, 16'h000C);
		tick();
		chk("masked rdata", rdata, 8'h3F);
		chk("bit test set", bit_test, 1'b1);
		bitop_mask = 8'h80;
		#1;
		tick();
		chk("bit test zero", bit_test, 1'b0);
		bitop_mask = 8'h00;
		req(1'b0, 1'b0, 16'hFFB3);
		chk("flash addr", flash_addr, 16'hFFB3);
		tick();
		chk("nv rdata", rdata, 8'h3C);
		// Dash bits may read either way, so only defined bits count
		periph_rdata = 8'hFF;
		periph_zero_mask = 8'h0C;
		req(1'b0, 1'b0, 16'h0011);
		tick();
		chk("defined bits", rdata & 8'hFC, 8'hF0);
		periph_zero_mask = 8'h00;
	endtask

	// Plain write passes; flash, vector and reserved writes do not
	task automatic test_writes;
		tick();
		req(1'b1, 1'b0, 16'h0001);
		chk("dp wr", periph_sel.wr, 1'b1);
		chk("dp wdata", periph_sel.wdata, 8'h5A);
		tick();
		periph_rdata = 8'h0F;
		bitop_mask = 8'h40;
		bitop_set = 1'b1;
		req(1'b1, 1'b1, 16'h0002);
		chk("bit set", periph_sel.wdata, 8'h4F);
		tick();
		bitop_set = 1'b0;
		bitop_clr = 1'b1;
		bitop_mask = 8'h01;
		req(1'b1, 1'b1, 16'h0002);
		chk("bit clear", periph_sel.wdata, 8'h0E);
		tick();
		bitop_clr = 1'b0;
		bitop_mask = 8'h00;
		periph_impl_mask = 8'h3F;
		req(1'b1, 1'b0, 16'h000C);
		chk("impl bits", periph_sel.wdata, 8'h1A);
		tick();
		req(1'b1, 1'b0, 16'hFFB5);
		chk("nv wr", periph_sel.wr, 1'b0);
		tick();
		req(1'b1, 1'b0, 16'hFFFE);
		chk("vec wr", periph_sel.wr, 1'b0);
		tick();
		periph_impl_mask = 8'h00;
		req(1'b1, 1'b0, 16'h001A);
		chk("reserved wr", periph_sel.wr, 1'b0);
		tick();
		core_req.valid = 1'b0;
		periph_impl_mask = 8'hFF;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		test_reset();
		test_vectors();
		test_decode();
		test_read();
		test_writes();
		test_reset();
		conclude();
	end
endmodule // vmd_decode_tb
